/* inc/ring_qual_pkg.sv */
/*
  Package for the ring frequency qualifier: register map, field layouts,
  reset values, timing constants, state codes and APB carrier structs.
  Assumes a 100 MHz system clock and an APB master with 32-bit data.
*/
package ring_qual_pkg;
  // Clock and timing base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam int MS_W = 17;
  localparam logic [0:0] TICK_HALF_LAST = 1'h1; // Two 1 ms steps make the 2 ms tick
  localparam int TIME_W = 11;
  localparam logic [TIME_W-1:0] TIME_MAX = 11'h7ff;
  // Decode units in ms
  localparam logic [TIME_W-1:0] DELAY_UNIT_MS = 11'h100;
  localparam logic [TIME_W-1:0] TIMEOUT_UNIT_MS = 11'h080;
  localparam logic [TIME_W-1:0] CONF_T0 = 11'h064;
  localparam logic [TIME_W-1:0] CONF_T1 = 11'h096;
  localparam logic [TIME_W-1:0] CONF_T2 = 11'h0c8;
  localparam logic [TIME_W-1:0] CONF_T3 = 11'h100;
  localparam logic [TIME_W-1:0] CONF_T4 = 11'h180;
  localparam logic [TIME_W-1:0] CONF_T5 = 11'h200;
  localparam logic [TIME_W-1:0] CONF_T6 = 11'h280;
  localparam logic [TIME_W-1:0] CONF_T7 = 11'h400;
  localparam logic [3:0] TIMEOUT_FORBIDDEN = 4'h0;
  localparam logic [3:0] TIMEOUT_FALLBACK = 4'h1;
  // Register indices and byte addresses
  localparam logic [7:0] IDX_CTRL1 = 8'h16;
  localparam logic [7:0] IDX_CTRL2 = 8'h17;
  localparam logic [7:0] IDX_CTRL3 = 8'h18;
  localparam logic [7:0] ADDR_CTRL1 = 8'(IDX_CTRL1 << 2);
  localparam logic [7:0] ADDR_CTRL2 = 8'(IDX_CTRL2 << 2);
  localparam logic [7:0] ADDR_CTRL3 = 8'(IDX_CTRL3 << 2);
  localparam logic [7:0] ADDR_STATUS = 8'h70;
  localparam logic [7:0] ADDR_MASK = 8'h74;
  localparam logic [7:0] ADDR_STATE = 8'h78;
  localparam logic [7:0] CTRL1_RST = 8'h96;
  localparam logic [7:0] CTRL2_RST = 8'h2d;
  localparam logic [7:0] CTRL3_RST = 8'h19;
  // Status bits
  localparam int STS_W = 3;
  localparam int STS_START = 0;
  localparam int STS_END = 1;
  localparam int STS_REJECT = 2;
  localparam logic [STS_W-1:0] STS_NONE = 3'h0;
  // Register layouts
  typedef struct packed {
    logic [1:0] ring_indicate_delay_lo;
    logic [5:0] ring_max_freq_limit;
  } ctrl_one_s;
  typedef struct packed {
    logic ring_indicate_delay_hi;
    logic [3:0] ring_end_timeout;
    logic [2:0] ring_confirm_time;
  } ctrl_two_s;
  typedef struct packed {
    logic [1:0] spare;
    logic [5:0] min_period_load;
  } ctrl_three_s;
  // Qualifier states, Gray along idle-confirm-delay-ringing
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONFIRM = 2'b01,
    ST_DELAY = 2'b11,
    ST_RINGING = 2'b10
  } qual_state_e;
  // APB carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;
endpackage

/* hw/ring_freq_qualifier.sv */
/*
  Ring frequency qualifier with APB register slave and interrupt.
  Assumes tr_event is a one-cycle pulse synchronous to clk from the
  line-side ring threshold detector, and an APB master on clk.
*/
// The APB interface to the registers was decided locally.
// What this block does
// - Rejects rings faster than the programmed maximum-frequency limit, about ten percent tolerance.
// - Each tip/ring event loads the qualification timer, which counts down every 2 ms.
// - On the next event, remaining timer above the limit marks the ring invalid.
// - Load minus limit gives the shortest accepted event gap in 2 ms units.
// - Validated ring is indicated after a 0 to 1792 ms programmable delay.
// - Ring ends after timeout of 128 ms steps since last crossing; 0000 forbidden, but the code accepts it and times out as for 0001 (128 ms).
// - Ring is valid after frequency stays in tolerance for the confirmation time.
`timescale 1ns/1ps
module ring_freq_qualifier #(
  parameter int MS_CYCLES = ring_qual_pkg::MS_CYCLES_DFLT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire ring_qual_pkg::apb_req_s apb_req,
  output ring_qual_pkg::apb_rsp_s apb_rsp,
  input wire logic tr_event,
  output logic ring_valid,
  output logic irq
);
  import ring_qual_pkg::*;

  // Delay code in ms; codes between 010 and 111 follow the same 256 ms step
  function automatic logic [TIME_W-1:0] delay_ms(input logic [2:0] code);
    delay_ms = TIME_W'(code * DELAY_UNIT_MS);
  endfunction

  // Timeout code in ms; the forbidden code acts as the shortest step
  function automatic logic [TIME_W-1:0] timeout_ms(input logic [3:0] code);
    logic [3:0] c;
    c = (code == TIMEOUT_FORBIDDEN) ? TIMEOUT_FALLBACK : code;
    timeout_ms = TIME_W'(c * TIMEOUT_UNIT_MS);
  endfunction

  // Confirmation code in ms
  function automatic logic [TIME_W-1:0] confirm_ms(input logic [2:0] code);
    unique case (code)
      3'h0: confirm_ms = CONF_T0;
      3'h1: confirm_ms = CONF_T1;
      3'h2: confirm_ms = CONF_T2;
      3'h3: confirm_ms = CONF_T3;
      3'h4: confirm_ms = CONF_T4;
      3'h5: confirm_ms = CONF_T5;
      3'h6: confirm_ms = CONF_T6;
      3'h7: confirm_ms = CONF_T7;
    endcase
  endfunction

  ctrl_one_s ctrl1_q, ctrl1_d;
  ctrl_two_s ctrl2_q, ctrl2_d;
  ctrl_three_s ctrl3_q, ctrl3_d;
  logic [STS_W-1:0] sts_q, sts_d, mask_q, mask_d;
  apb_rsp_s rsp_q, rsp_d;
  logic irq_q, irq_d;
  qual_state_e state_q, state_d;
  logic [MS_W-1:0] ms_cnt_q, ms_cnt_d;
  logic half_q, half_d;
  logic [5:0] qtmr_q, qtmr_d;
  logic [TIME_W-1:0] gap_q, gap_d, phase_q, phase_d;
  logic armed_q, armed_d, valid_q, valid_d;
  logic ms_tick, tick2, too_fast, timed_out, setup, access;
  logic [STS_W-1:0] ev;

  assign apb_rsp = rsp_q;
  assign ring_valid = valid_q;
  assign irq = irq_q;

  // Time base and event decode
  always_comb begin
    ms_tick = (ms_cnt_q == MS_W'(MS_CYCLES - 1));
    tick2 = ms_tick && (half_q == TICK_HALF_LAST);
    too_fast = tr_event && armed_q && (qtmr_q > ctrl1_q.ring_max_freq_limit);
    timed_out = armed_q && (gap_q >= timeout_ms(ctrl2_q.ring_end_timeout));
    setup = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable && rsp_q.pready;
  end

  // Qualifier next state
  always_comb begin
    ms_cnt_d = ms_tick ? '0 : ms_cnt_q + 1'b1;
    half_d = ms_tick ? ~half_q : half_q;
    qtmr_d = qtmr_q;
    gap_d = gap_q;
    phase_d = phase_q;
    armed_d = armed_q;
    state_d = state_q;
    ev = STS_NONE;
    // Interval timer: load on event, count down, stop at zero
    if (tr_event) begin
      qtmr_d = ctrl3_q.min_period_load;
    end else if (tick2 && qtmr_q != '0) begin
      qtmr_d = qtmr_q - 1'b1;
    end
    // Time since the latest crossing, saturating
    if (tr_event) begin
      gap_d = '0;
    end else if (ms_tick && gap_q != TIME_MAX) begin
      gap_d = gap_q + 1'b1;
    end
    if (ms_tick && phase_q != TIME_MAX) begin
      phase_d = phase_q + 1'b1;
    end
    if (tr_event) begin
      armed_d = 1'b1;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (tr_event && !too_fast) begin
          state_d = ST_CONFIRM;
          phase_d = '0;
        end
      end
      ST_CONFIRM: begin
        if (phase_q >= confirm_ms(ctrl2_q.ring_confirm_time)) begin
          state_d = ST_DELAY;
          phase_d = '0;
        end
      end
      ST_DELAY: begin
        if (phase_q >= delay_ms({ctrl2_q.ring_indicate_delay_hi,
                                 ctrl1_q.ring_indicate_delay_lo})) begin
          state_d = ST_RINGING;
          ev[STS_START] = 1'b1;
        end
      end
      ST_RINGING: ;
    endcase
    // Too fast or timed out drops back to idle from any active state
    if (state_q != ST_IDLE && too_fast) begin
      state_d = ST_IDLE;
      ev[STS_REJECT] = 1'b1;
      ev[STS_END] = (state_q == ST_RINGING);
    end else if (state_q != ST_IDLE && timed_out && !tr_event) begin
      state_d = ST_IDLE;
      armed_d = 1'b0;
      ev[STS_END] = (state_q == ST_RINGING);
    end else if (state_q == ST_IDLE && too_fast) begin
      ev[STS_REJECT] = 1'b1;
    end else if (state_q == ST_IDLE && timed_out && !tr_event) begin
      armed_d = 1'b0;
    end
    valid_d = (state_d == ST_RINGING);
  end

  // Register file, sticky status and APB answer
  always_comb begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    ctrl3_d = ctrl3_q;
    mask_d = mask_q;
    sts_d = sts_q;
    rsp_d = '0;
    if (access && apb_req.pwrite) begin
      unique case (apb_req.paddr)
        ADDR_CTRL1: ctrl1_d = apb_req.pwdata[7:0];
        ADDR_CTRL2: ctrl2_d = apb_req.pwdata[7:0];
        ADDR_CTRL3: ctrl3_d = apb_req.pwdata[7:0];
        ADDR_MASK: mask_d = apb_req.pwdata[STS_W-1:0];
        default: ;
      endcase
    end
    // Read clears status; a new event in the same cycle wins
    if (access && !apb_req.pwrite && apb_req.paddr == ADDR_STATUS) begin
      sts_d = STS_NONE;
    end
    sts_d = sts_d | ev;
    if (setup) begin
      rsp_d.pready = 1'b1;
      unique case (apb_req.paddr)
        ADDR_CTRL1: rsp_d.prdata = 32'(ctrl1_q);
        ADDR_CTRL2: rsp_d.prdata = 32'(ctrl2_q);
        ADDR_CTRL3: rsp_d.prdata = 32'(ctrl3_q);
        ADDR_STATUS: rsp_d.prdata = 32'(sts_q | ev); // A flag set now is reported, not lost
        ADDR_MASK: rsp_d.prdata = 32'(mask_q);
        ADDR_STATE: rsp_d.prdata = 32'({qtmr_q, state_q});
        default: rsp_d.pslverr = 1'b1;
      endcase
    end
    irq_d = |(sts_d & mask_d);
  end

  // State registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      ctrl3_q <= CTRL3_RST;
      mask_q <= STS_NONE;
      sts_q <= STS_NONE;
      rsp_q <= '0;
      irq_q <= 1'b0;
      state_q <= ST_IDLE;
      ms_cnt_q <= '0;
      half_q <= 1'b0;
      qtmr_q <= '0;
      gap_q <= '0;
      phase_q <= '0;
      armed_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      ctrl3_q <= ctrl3_d;
      mask_q <= mask_d;
      sts_q <= sts_d;
      rsp_q <= rsp_d;
      irq_q <= irq_d;
      state_q <= state_d;
      ms_cnt_q <= ms_cnt_d;
      half_q <= half_d;
      qtmr_q <= qtmr_d;
      gap_q <= gap_d;
      phase_q <= phase_d;
      armed_q <= armed_d;
      valid_q <= valid_d;
    end
  end

  // Checks
  property p_load;
    @(posedge clk) disable iff (!nrst) tr_event |=> qtmr_q == $past(ctrl3_q.min_period_load);
  endproperty
  a_load: assert property (p_load) else $error("timer not loaded");
  property p_nowrap;
    @(posedge clk) disable iff (!nrst) (qtmr_q == '0 && !tr_event) |=> qtmr_q == '0;
  endproperty
  a_nowrap: assert property (p_nowrap) else $error("timer wrapped");
  property p_down;
    @(posedge clk) disable iff (!nrst)
      (tick2 && !tr_event && qtmr_q != '0) |=> qtmr_q == $past(qtmr_q) - 6'h1;
  endproperty
  a_down: assert property (p_down) else $error("timer did not count");
  property p_reject;
    @(posedge clk) disable iff (!nrst)
      (tr_event && armed_q && qtmr_q > ctrl1_q.ring_max_freq_limit && state_q != ST_IDLE)
      |=> state_q == ST_IDLE && sts_q[STS_REJECT];
  endproperty
  a_reject: assert property (p_reject) else $error("fast ring not rejected");
  property p_confirm;
    @(posedge clk) disable iff (!nrst)
      (state_q == ST_CONFIRM && $changed(state_q)) |=> phase_q <= 11'h1;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm phase not cleared");
  property p_delay_done;
    @(posedge clk) disable iff (!nrst)
      ($rose(ring_valid) && $past(state_q) == ST_DELAY)
      |-> $past(phase_q) >= delay_ms({ctrl2_q.ring_indicate_delay_hi,
                                      ctrl1_q.ring_indicate_delay_lo});
  endproperty
  a_delay_done: assert property (p_delay_done) else $error("indicated too early");
  property p_valid;
    @(posedge clk) disable iff (!nrst) $rose(ring_valid) |-> sts_q[STS_START];
  endproperty
  a_valid: assert property (p_valid) else $error("indication mismatch");
  sequence s_ringing_timeout;
    state_q == ST_RINGING && timed_out && !tr_event && !too_fast;
  endsequence
  property p_end;
    @(posedge clk) disable iff (!nrst) s_ringing_timeout |=> !ring_valid && sts_q[STS_END];
  endproperty
  a_end: assert property (p_end) else $error("ring end missed");
  property p_sticky;
    @(posedge clk) disable iff (!nrst) $rose(sts_q[STS_START]) |-> $past(state_q) == ST_DELAY;
  endproperty
  a_sticky: assert property (p_sticky) else $error("start flag without delay");
endmodule // ring_freq_qualifier

/* tb/ring_event_source.sv */
/*
  Line-side ring threshold detector model: one-cycle crossing pulses.
  Assumes the bench sets run and gap just after a rising clock edge.
*/
`timescale 1ns/1ps
module ring_event_source (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [15:0] gap,
  output logic tr_event
);
  logic [15:0] cnt_q;
  // Pulse once every gap clocks while run is high, quiet otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 16'h0000;
      tr_event <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tr_event <= 1'b0;
    end else begin
      tr_event <= (cnt_q == 16'h0000);
      cnt_q <= (cnt_q == gap - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
endmodule // ring_event_source

/* tb/ring_freq_qualifier_test.sv */
/*
  Self-checking bench for the ring qualifier: registers, timing, reject.
  Assumes MS_CYCLES of 10, so 1 ms is 10 clocks and the 2 ms tick 20.
*/
`timescale 1ns/1ps
module ring_freq_qualifier_test;
  import ring_qual_pkg::*;
  logic clk;
  logic nrst;
  apb_req_s req;
  apb_rsp_s rsp;
  logic tr_event;
  logic ring_valid;
  logic irq;
  logic run;
  logic [15:0] gap;
  logic [31:0] rdat;
  logic err;
  int failures;
  int comparisons;
  ring_freq_qualifier #(.MS_CYCLES(10)) u_dut (.clk(clk), .nrst(nrst), .apb_req(req),
    .apb_rsp(rsp), .tr_event(tr_event), .ring_valid(ring_valid), .irq(irq));
  ring_event_source u_src (.clk(clk), .nrst(nrst), .run(run), .gap(gap), .tr_event(tr_event));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: no pready from the slave", $time);
    end
    rdat = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // Read and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp, what);
  endtask
  // Reset values, read-write access and an unmapped address
  task automatic t_reset();
    rd(ADDR_CTRL1, 32'h0000_0096, "ctrl1 reset");
    rd(ADDR_CTRL2, 32'h0000_002d, "ctrl2 reset");
    rd(ADDR_CTRL3, 32'h0000_0019, "ctrl3 reset");
    rd(ADDR_MASK, 32'h0000_0000, "mask reset");
    rd(8'h00, 32'h0000_0000, "unmapped read");
    chk(32'(err), 32'h0000_0001, "unmapped error");
    apb(1'b1, ADDR_CTRL2, 32'h0000_007f);
    rd(ADDR_CTRL2, 32'h0000_007f, "ctrl2 readback");
    apb(1'b1, ADDR_CTRL3, 32'h0000_000a);
    $display("test reset done");
  endtask
  // Ring of accepted events: indication time, interrupt, ring end
  task automatic t_ring(input logic [2:0] dly, input logic [2:0] conf, input int exp);
    int n;
    apb(1'b1, ADDR_CTRL1, {24'h00_0000, dly[1:0], 6'h05}); // Limit 5 under load 10
    apb(1'b1, ADDR_CTRL2, {24'h00_0000, dly[2], 4'h1, conf});
    apb(1'b1, ADDR_MASK, 32'h0000_0001);
    gap <= 16'h00a0;
    run <= 1'b1;
    n = 0;
    while (ring_valid !== 1'b1 && n < exp + 100) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n > exp - 20 && n < exp + 40), 32'h0000_0001, "indication time");
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0000_0001, "irq on ring start");
    rd(ADDR_STATUS, 32'h0000_0001, "ring start flag");
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0000_0000, "irq after status read");
    // Stop right after a crossing so the timeout is measured from it
    n = 0;
    while (tr_event !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(32'(tr_event), 32'h0000_0001, "crossing before stop");
    run <= 1'b0;
    n = 0;
    while (ring_valid !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n > 1240 && n < 1320), 32'h0000_0001, "ring end time");
    rd(ADDR_STATUS, 32'h0000_0002, "ring end flag");
    $display("test ring done");
  endtask
  // Too fast a ring is rejected, then the timer rests at zero
  task automatic t_fast();
    gap <= 16'h0028;
    run <= 1'b1;
    repeat (200) @(posedge clk);
    run <= 1'b0;
    chk(32'(ring_valid), 32'h0000_0000, "fast ring indicated");
    rd(ADDR_STATUS, 32'h0000_0004, "reject flag");
    repeat (300) @(posedge clk);
    rd(ADDR_STATE, 32'h0000_0000, "timer held at zero");
    $display("test fast done");
  endtask
  // Print counts and verdict, end the run
  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    failures = 0;
    comparisons = 0;
    nrst = 1'b0;
    req = '0;
    run = 1'b0;
    gap = 16'h0000;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_ring(3'h0, 3'h0, 1000);
    t_ring(3'h1, 3'h0, 3560);
    t_ring(3'h0, 3'h7, 10240);
    t_ring(3'h7, 3'h0, 18920);
    t_fast();
    complete_run();
  end
  // Watchdog against a hang
  initial begin
    #600000;
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule // ring_freq_qualifier_test
